// File: ica_defines.svh
// Constants for the interrupt accept controller: register offsets, reset values,
// vector numbers and exception entry state counts.
// Assumes inclusion by the package, the controller and the testbench.
`ifndef ICA_DEFINES_SVH
`define ICA_DEFINES_SVH
// APB byte offsets
`define ICA_OFF_FLAGS_ONE 8'h00
`define ICA_OFF_FLAGS_TWO 8'h04
`define ICA_OFF_ENABLE_ONE 8'h08
`define ICA_OFF_ENABLE_TWO 8'h0C
`define ICA_OFF_PIN_FUNC 8'h10
`define ICA_OFF_EDGE_SEL 8'h14
`define ICA_OFF_CCR 8'h18
`define ICA_OFF_SP 8'h1C
`define ICA_OFF_STATUS 8'h20
// Reset values
`define ICA_RST_CCR 8'h80
`define ICA_RST_SP 16'hFF80
// Field positions
`define ICA_CCR_I_BIT 7
`define ICA_EDGE_FIRST 4
// Vector numbers
`define ICA_VEC_PIN0 5'h04
`define ICA_VEC_EDGE 5'h08
`define ICA_VEC_INT_FIRST 5'h09
`define ICA_VEC_INT_SPAN 14
// Exception entry state counts
`define ICA_N_STACK 4'h4
`define ICA_N_VFETCH 4'h2
`define ICA_N_IFETCH 4'h4
`define ICA_N_INTPROC 4'h4
`endif

// File: ica_pkg.sv
// Types shared by the interrupt accept controller.
// Assumes the constants header sits in the same folder.
package ica_pkg;
  `include "ica_defines.svh"
  typedef enum logic [2:0] {
    ICA_IDLE, ICA_STACK, ICA_VFETCH, ICA_IFETCH, ICA_INTPROC
  } ica_state_e;
  typedef logic [20:0] ica_src_t;
  typedef logic [11:0] ica_ext_t;
  typedef logic [15:0] ica_word_t;
endpackage : ica_pkg

// File: ica_ctrl.sv
// Interrupt accept controller: request flags, enables, priority choice and the
// exception entry sequence (stacking, vector fetch, handler start).
// Assumes a CPU that pulses INSTR_DONE at instruction boundaries, supplies the
// next PC, and serves one memory word per access; pins are asynchronous.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "ica_defines.svh"

module ica_ctrl
  import ica_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Request sources
  input wire logic [20:0] SRC_REQ,
  input wire logic [3:0] EXT_REQ_PIN,
  input wire logic [7:0] EDGE_PIN,
  // CPU side
  input wire logic INSTR_DONE,
  input wire logic [15:0] NEXT_PC,
  input wire logic [15:0] VEC_RDATA,
  input wire logic RET_STROBE,
  input wire logic [15:0] RET_CCR_WORD,
  output logic ENTRY_BUSY,
  output logic IMASK,
  output logic [4:0] ACCEPT_VEC,
  output logic MEM_WE,
  output logic MEM_RE,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output logic [15:0] HANDLER_PC,
  output logic HANDLER_GO
);

  ica_src_t int_flags_r, en_one_r, int_set, int_rec;
  ica_ext_t ext_flags_r, en_two_r, ext_set, ext_rec;
  logic [3:0] pin_func_r, pmr_prev_r, phase_r;
  logic [11:0] edge_sel_r, sync1_r, sync2_r, prev_r, lvl;
  logic [7:0] ccr_r, ccr_save_r;
  ica_word_t sp_r;
  ica_state_e state_r;
  logic [4:0] vec_r, sel_vec;
  logic clr_guard_r, any_rec, accept;
  logic wr_en, rd_setup, mapped, wr_flags_one, wr_flags_two, wr_pin_func;
  logic [31:0] rd_mux;
  // Fixed priority table: internal source index to vector number
  function automatic logic [4:0] int_vec(input int idx);
    int v;
    v = idx * `ICA_VEC_INT_SPAN / 20;
    return 5'(`ICA_VEC_INT_FIRST + 5'(v));
  endfunction : int_vec
  // APB decode; the slave never waits
  assign PREADY = 1'b1;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign wr_flags_one = wr_en && (PADDR == `ICA_OFF_FLAGS_ONE);
  assign wr_flags_two = wr_en && (PADDR == `ICA_OFF_FLAGS_TWO);
  assign wr_pin_func = wr_en && (PADDR == `ICA_OFF_PIN_FUNC);
  assign PSLVERR = PSEL && PENABLE && !mapped;
  // Read multiplexer
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `ICA_OFF_FLAGS_ONE: rd_mux = {11'h000, int_flags_r};
      `ICA_OFF_FLAGS_TWO: rd_mux = {20'h00000, ext_flags_r};
      `ICA_OFF_ENABLE_ONE: rd_mux = {11'h000, en_one_r};
      `ICA_OFF_ENABLE_TWO: rd_mux = {20'h00000, en_two_r};
      `ICA_OFF_PIN_FUNC: rd_mux = {28'h0000000, pin_func_r};
      `ICA_OFF_EDGE_SEL: rd_mux = {20'h00000, edge_sel_r};
      `ICA_OFF_CCR: rd_mux = {24'h000000, ccr_r};
      `ICA_OFF_SP: rd_mux = {16'h0000, sp_r};
      `ICA_OFF_STATUS: rd_mux = {20'h00000, clr_guard_r, state_r, vec_r, ENTRY_BUSY,
        1'b0, any_rec};
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= rd_mux;
    end
  end
  // Plain control registers
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      en_one_r <= 21'h000000;
      en_two_r <= 12'h000;
      pin_func_r <= 4'h0;
      edge_sel_r <= 12'h000;
    end else if (wr_en) begin
      if (PADDR == `ICA_OFF_ENABLE_ONE) en_one_r <= PWDATA[20:0];
      if (PADDR == `ICA_OFF_ENABLE_TWO) en_two_r <= PWDATA[11:0];
      if (PADDR == `ICA_OFF_PIN_FUNC) pin_func_r <= PWDATA[3:0];
      if (PADDR == `ICA_OFF_EDGE_SEL) edge_sel_r <= PWDATA[11:0];
    end
  end
  // Pin synchronisers, edge history and previous pin function bits
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1_r <= 12'hFFF;
      sync2_r <= 12'hFFF;
      prev_r <= 12'hFFF;
      pmr_prev_r <= 4'h0;
    end else begin
      sync1_r <= {EDGE_PIN, EXT_REQ_PIN};
      sync2_r <= sync1_r;
      prev_r <= lvl;
      pmr_prev_r <= pin_func_r;
    end
  end
  // Per pin edge detection; a deselected request pin 1 to 3 looks high internally, a deselected pin 0 has its edges gated off
  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_pin
      if (g >= 1 && g <= 3) begin : g_mux
        assign lvl[g] = pin_func_r[g] ? sync2_r[g] : 1'b1;
      end else begin : g_raw
        assign lvl[g] = sync2_r[g];
      end
      if (g == 0) begin : g_p0
        assign ext_set[g] = en_two_r[g] && pin_func_r[0] && pmr_prev_r[0] &&
          (edge_sel_r[g] ? (!prev_r[g] && lvl[g]) : (prev_r[g] && !lvl[g]));
      end else begin : g_pn
        assign ext_set[g] = en_two_r[g] &&
          (edge_sel_r[g] ? (!prev_r[g] && lvl[g]) : (prev_r[g] && !lvl[g]));
      end
    end
  endgenerate
  // Internal requests reach the flags only while enabled
  assign int_set = SRC_REQ & en_one_r;
  // Internal flags: a set wins over a clear; only a written zero clears
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      int_flags_r <= 21'h000000;
    end else begin
      int_flags_r <= (int_flags_r & (wr_flags_one ? PWDATA[20:0] : 21'h1FFFFF)) | int_set;
    end
  end
  // Clear guard: armed by a pin function write, released by the next instruction
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      clr_guard_r <= 1'b0;
    end else if (wr_pin_func) begin
      clr_guard_r <= 1'b1;
    end else if (INSTR_DONE) begin
      clr_guard_r <= 1'b0;
    end
  end
  // Pin flags: clears ignored while the guard is armed
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ext_flags_r <= 12'h000;
    end else if (wr_flags_two && !clr_guard_r) begin
      ext_flags_r <= (ext_flags_r & PWDATA[11:0]) | ext_set;
    end else begin
      ext_flags_r <= ext_flags_r | ext_set;
    end
  end
  // Recognised requests and priority choice; later assignments win
  assign int_rec = int_flags_r & en_one_r;
  assign ext_rec = ext_flags_r & en_two_r;
  always_comb begin
    sel_vec = 5'h00;
    any_rec = 1'b0;
    for (int i = 20; i >= 0; i--) begin
      if (int_rec[i]) begin
        sel_vec = int_vec(i);
        any_rec = 1'b1;
      end
    end
    if (|ext_rec[11:`ICA_EDGE_FIRST]) begin
      sel_vec = `ICA_VEC_EDGE;
      any_rec = 1'b1;
    end
    for (int i = 3; i >= 0; i--) begin
      if (ext_rec[i]) begin
        sel_vec = 5'(`ICA_VEC_PIN0 + 5'(i));
        any_rec = 1'b1;
      end
    end
  end
  // Acceptance waits for the instruction boundary, so a colliding clear completes first
  assign accept = (state_r == ICA_IDLE) && any_rec && !ccr_r[`ICA_CCR_I_BIT] &&
    INSTR_DONE;
  // Entry sequencer
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= ICA_IDLE;
      phase_r <= 4'h0;
    end else begin
      phase_r <= 4'(phase_r + 4'h1);
      case (state_r)
        ICA_IDLE: begin
          phase_r <= 4'h0;
          if (accept) state_r <= ICA_STACK;
        end
        ICA_STACK: if (phase_r == `ICA_N_STACK - 4'h1) begin
          state_r <= ICA_VFETCH;
          phase_r <= 4'h0;
        end
        ICA_VFETCH: if (phase_r == `ICA_N_VFETCH - 4'h1) begin
          state_r <= ICA_IFETCH;
          phase_r <= 4'h0;
        end
        ICA_IFETCH: if (phase_r == `ICA_N_IFETCH - 4'h1) begin
          state_r <= ICA_INTPROC;
          phase_r <= 4'h0;
        end
        ICA_INTPROC: if (phase_r == `ICA_N_INTPROC - 4'h1) begin
          state_r <= ICA_IDLE;
          phase_r <= 4'h0;
        end
        default: state_r <= ICA_IDLE;
      endcase
    end
  end
  // Latched vector and the condition code as it stood before the mask was set
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      vec_r <= 5'h00;
      ccr_save_r <= 8'h00;
    end else if (accept) begin
      vec_r <= sel_vec;
      ccr_save_r <= ccr_r;
    end
  end
  // Condition code: mask set on entry, even byte restored on return, else software
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ccr_r <= `ICA_RST_CCR;
    end else if (accept) begin
      ccr_r[`ICA_CCR_I_BIT] <= 1'b1;
    end else if (RET_STROBE && state_r == ICA_IDLE) begin
      ccr_r <= RET_CCR_WORD[15:8];
    end else if (wr_en && PADDR == `ICA_OFF_CCR) begin
      ccr_r <= PWDATA[7:0];
    end
  end
  // Stack pointer: two words pushed on entry, two popped on return; accept wins
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sp_r <= `ICA_RST_SP;
    end else if (state_r == ICA_STACK && phase_r == `ICA_N_STACK - 4'h1) begin
      sp_r <= 16'(sp_r - 16'h0004);
    end else if (RET_STROBE && state_r == ICA_IDLE && !accept) begin
      sp_r <= 16'(sp_r + 16'h0004);
    end else if (wr_en && PADDR == `ICA_OFF_SP) begin
      sp_r <= PWDATA[15:0];
    end
  end
  // Memory port: PC then CONDITION_CODE_REG word pushed, then vector word read
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MEM_WE <= 1'b0;
      MEM_RE <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 16'h0000;
    end else begin
      MEM_WE <= 1'b0;
      MEM_RE <= 1'b0;
      if (accept) begin
        MEM_WE <= 1'b1;
        MEM_ADDR <= {sp_r[15:1] - 15'h0001, 1'b0};
        MEM_WDATA <= NEXT_PC;
      end else if (state_r == ICA_STACK && phase_r == 4'h1) begin
        MEM_WE <= 1'b1;
        MEM_ADDR <= {sp_r[15:1] - 15'h0002, 1'b0};
        MEM_WDATA <= {ccr_save_r, ccr_save_r};
      end else if (state_r == ICA_STACK && phase_r == `ICA_N_STACK - 4'h1) begin
        MEM_RE <= 1'b1;
        MEM_ADDR <= {10'h000, vec_r, 1'b0};
      end
    end
  end
  // Handler address captured at the end of the vector fetch, start pulsed after entry
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HANDLER_PC <= 16'h0000;
      HANDLER_GO <= 1'b0;
    end else begin
      HANDLER_GO <= (state_r == ICA_INTPROC) && (phase_r == `ICA_N_INTPROC - 4'h1);
      if (state_r == ICA_VFETCH && phase_r == `ICA_N_VFETCH - 4'h1) begin
        HANDLER_PC <= VEC_RDATA;
      end
    end
  end
  // Status outputs
  assign ENTRY_BUSY = (state_r != ICA_IDLE);
  assign IMASK = ccr_r[`ICA_CCR_I_BIT];
  assign ACCEPT_VEC = vec_r;
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_stack; (state_r == ICA_STACK) [*4]; endsequence
  sequence s_fetch; (state_r == ICA_VFETCH) [*2] ##1 (state_r == ICA_IFETCH) [*4]; endsequence
  sequence s_finish; (state_r == ICA_INTPROC) [*4] ##1 HANDLER_GO; endsequence
  a_entry_timing: assert property (accept |=> s_stack ##1 s_fetch ##1 s_finish)
    else $error("entry sequence length wrong");
  a_mask_on_entry: assert property (accept |=> IMASK && ENTRY_BUSY)
    else $error("mask not set on entry");
  a_mask_holds: assert property (!ENTRY_BUSY && IMASK |=> !ENTRY_BUSY)
    else $error("request accepted while masked");
  a_flag_sets: assert property (int_set != 21'h000000 |=>
    (int_flags_r & $past(int_set)) == $past(int_set))
    else $error("internal flag not set");
  a_flag_sticky: assert property (!wr_flags_one |=>
    (int_flags_r & $past(int_flags_r)) == $past(int_flags_r))
    else $error("flag cleared without write");
  a_guard_clear: assert property (clr_guard_r && wr_flags_two |=>
    (ext_flags_r & $past(ext_flags_r)) == $past(ext_flags_r))
    else $error("guarded clear took effect");
  a_even_addr: assert property (MEM_WE || MEM_RE |-> !MEM_ADDR[0])
    else $error("odd word address");
  a_ret_ccr: assert property (RET_STROBE && !ENTRY_BUSY && !accept |=>
    ccr_r == $past(RET_CCR_WORD[15:8]))
    else $error("CONDITION_CODE_REG not restored from even byte");
  a_pin0_first: assert property (accept && ext_rec[0] |=> ACCEPT_VEC == 5'h04)
    else $error("pin 0 not highest priority");
  a_vec_fetch: assert property (accept |=> ##4 MEM_RE &&
    MEM_ADDR == {10'h000, ACCEPT_VEC, 1'b0})
    else $error("vector address wrong");
endmodule : ica_ctrl

// File: ica_cpu_model.sv
// CPU partner model: instruction boundaries, return address, vector table
// and the return-from-exception strobe with its popped condition code word.
// Assumes the controller's memory port and a bench that sets the boundary gap.
`timescale 1ns/100ps
module ica_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control, gap 8'hFF stops instruction boundaries
  input wire logic [7:0] gap,
  input wire logic ret_req,
  // Controller side
  input wire logic mem_re,
  input wire logic [15:0] mem_addr,
  output logic instr_done,
  output logic [15:0] next_pc,
  output logic [15:0] vec_rdata,
  output logic ret_strobe,
  output logic [15:0] ret_ccr_word
);
  logic [7:0] cnt_r;
  logic [1:0] hold_r;
  // Instruction boundary every gap+1 states, 1 to 255 in normal use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      instr_done <= 1'h0;
      next_pc <= 16'h1000;
    end else begin
      instr_done <= (cnt_r >= gap) && (gap != 8'hFF);
      cnt_r <= (cnt_r >= gap) ? 8'h00 : cnt_r + 8'h01;
      if ((cnt_r >= gap) && (gap != 8'hFF)) begin
        next_pc <= next_pc + 16'h0002; // Address of the next instruction
      end
    end
  end
  // Vector table word held two states, then a changed value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_r <= 2'h0;
      vec_rdata <= 16'h0000;
    end else if (mem_re) begin
      hold_r <= 2'h2;
      vec_rdata <= {4'hC, mem_addr[11:0]};
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
      if (hold_r == 2'h1) begin
        vec_rdata <= ~vec_rdata;
      end
    end
  end
  // Return strobe; even byte 8'h00 is the CONDITION_CODE_REG, odd byte must be dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ret_strobe <= 1'h0;
      ret_ccr_word <= 16'hFF00;
    end else begin
      ret_strobe <= ret_req;
      ret_ccr_word <= ret_req ? 16'h00FF : 16'hFF00;
    end
  end
endmodule : ica_cpu_model

// File: test_interrupt_accept_controller.sv
// Testbench for the interrupt accept controller: APB register tasks, request
// sources and cycle checks of the exception entry sequence.
// Assumes the CPU partner model and the controller's constants header.
`timescale 1ns/100ps
`include "ica_defines.svh"
module test_interrupt_accept_controller;
  logic CORE_CLK = 1'h0, SYS_RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic [7:0] PADDR = 8'h00, EDGE_PIN = 8'hFF, gap = 8'h03;
  logic [31:0] PWDATA = 32'h0, PRDATA, rdata;
  logic [20:0] SRC_REQ = 21'h0;
  logic [3:0] EXT_REQ_PIN = 4'hF;
  logic ret_req = 1'h0, err_seen;
  logic PREADY, PSLVERR, INSTR_DONE, RET_STROBE, ENTRY_BUSY, IMASK, MEM_WE, MEM_RE, HANDLER_GO;
  logic [15:0] NEXT_PC, VEC_RDATA, RET_CCR_WORD, MEM_ADDR, MEM_WDATA, HANDLER_PC;
  logic [15:0] sp_v = 16'hFF80;
  logic [4:0] ACCEPT_VEC;
  int bad_count = 0;
  int num_checks = 0;
  // Clock, 20 ns period
  always #10 CORE_CLK = ~CORE_CLK;
  ica_ctrl dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SRC_REQ(SRC_REQ), .EXT_REQ_PIN(EXT_REQ_PIN), .EDGE_PIN(EDGE_PIN),
    .INSTR_DONE(INSTR_DONE), .NEXT_PC(NEXT_PC), .VEC_RDATA(VEC_RDATA),
    .RET_STROBE(RET_STROBE), .RET_CCR_WORD(RET_CCR_WORD), .ENTRY_BUSY(ENTRY_BUSY),
    .IMASK(IMASK), .ACCEPT_VEC(ACCEPT_VEC), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .HANDLER_PC(HANDLER_PC),
    .HANDLER_GO(HANDLER_GO));
  ica_cpu_model cpu (.clk(CORE_CLK), .rst(SYS_RST), .gap(gap), .ret_req(ret_req),
    .mem_re(MEM_RE), .mem_addr(MEM_ADDR), .instr_done(INSTR_DONE), .next_pc(NEXT_PC),
    .vec_rdata(VEC_RDATA), .ret_strobe(RET_STROBE), .ret_ccr_word(RET_CCR_WORD));
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  // Compare one value
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'h1;
    do @(posedge CORE_CLK); while (PREADY !== 1'h1 && ++n < 50);
    if (PREADY !== 1'h1) begin
      bad_count++;
      $display("[ERR] %0t no ready from slave", $time);
    end
    rdata = PRDATA;
    err_seen = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd
  // One state pulse on internal request sources
  task automatic pulse(input logic [20:0] m);
    @(posedge CORE_CLK);
    SRC_REQ <= m;
    @(posedge CORE_CLK);
    SRC_REQ <= 21'h0;
  endtask : pulse
  // Whole entry sequence from the first stack write: both pushes, vector read, handler start
  task automatic entry(input logic [4:0] v, input logic [15:0] condition_code_reg);
    int n;
    n = 0;
    do @(negedge CORE_CLK); while (MEM_WE !== 1'h1 && ++n < 300);
    chk(MEM_WE, 1'h1);
    chk(MEM_ADDR, sp_v - 16'h2);
    chk(MEM_WDATA, NEXT_PC);
    chk(ACCEPT_VEC, v);
    chk(IMASK, 1'h1);
    repeat (2) @(negedge CORE_CLK);
    chk({MEM_WE, MEM_ADDR, MEM_WDATA}, {1'h1, sp_v - 16'h4, condition_code_reg});
    repeat (2) @(negedge CORE_CLK);
    chk({MEM_RE, MEM_ADDR}, {1'h1, 10'h0, v, 1'h0});
    repeat (9) @(negedge CORE_CLK);
    chk(HANDLER_GO, 1'h0);
    @(negedge CORE_CLK);
    chk({HANDLER_GO, HANDLER_PC}, {1'h1, 4'hC, 6'h0, v, 1'h0});
    sp_v = sp_v - 16'h4;
  endtask : entry
  // Watchdog
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    bad_count++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'h0;
    rd(`ICA_OFF_CCR, 32'h80);
    rd(`ICA_OFF_SP, 32'hFF80);
    rd(8'h24, 32'h0);
    chk(err_seen, 1'h1);
    pulse(21'h8);
    rd(`ICA_OFF_FLAGS_ONE, 32'h0);
    wr(`ICA_OFF_ENABLE_ONE, 32'h100009);
    pulse(21'h8);
    rd(`ICA_OFF_FLAGS_ONE, 32'h8);
    wr(`ICA_OFF_FLAGS_ONE, 32'hFFFFFFF7);
    rd(`ICA_OFF_FLAGS_ONE, 32'h0);
    pulse(21'h100001);
    repeat (40) @(posedge CORE_CLK);
    chk(ENTRY_BUSY, 1'h0);
    wr(`ICA_OFF_CCR, 32'h05);
    entry(5'h09, 16'h0505);
    rd(`ICA_OFF_FLAGS_ONE, 32'h100001);
    rd(`ICA_OFF_CCR, 32'h85);
    wr(`ICA_OFF_FLAGS_ONE, 32'hFFFFFFFE);
    wr(`ICA_OFF_CCR, 32'h05);
    entry(5'h17, 16'h0505);
    rd(`ICA_OFF_SP, 32'hFF78);
    wr(`ICA_OFF_FLAGS_ONE, 32'hFFEFFFFF);
    @(posedge CORE_CLK);
    ret_req <= 1'h1;
    @(posedge CORE_CLK);
    ret_req <= 1'h0;
    rd(`ICA_OFF_CCR, 32'h00);
    rd(`ICA_OFF_SP, 32'hFF7C);
    sp_v = 16'hFF7C;
    wr(`ICA_OFF_CCR, 32'h80);
    wr(`ICA_OFF_ENABLE_TWO, 32'hFFF);
    wr(`ICA_OFF_PIN_FUNC, 32'hF);
    EXT_REQ_PIN <= 4'h0;
    EDGE_PIN[5] <= 1'h0;
    repeat (8) @(posedge CORE_CLK);
    rd(`ICA_OFF_FLAGS_TWO, 32'h20F);
    wr(`ICA_OFF_CCR, 32'h05);
    entry(5'h04, 16'h0505);
    wr(`ICA_OFF_FLAGS_TWO, 32'hFFFFFFF0);
    wr(`ICA_OFF_CCR, 32'h05);
    entry(5'h08, 16'h0505);
    wr(`ICA_OFF_FLAGS_TWO, 32'hFFFFFDFF);
    rd(`ICA_OFF_FLAGS_TWO, 32'h0);
    gap <= 8'hFF;
    wr(`ICA_OFF_PIN_FUNC, 32'hB);
    wr(`ICA_OFF_PIN_FUNC, 32'hF);
    repeat (8) @(posedge CORE_CLK);
    rd(`ICA_OFF_FLAGS_TWO, 32'h4);
    wr(`ICA_OFF_FLAGS_TWO, 32'hFFFFFFFB);
    rd(`ICA_OFF_FLAGS_TWO, 32'h4);
    gap <= 8'h03;
    repeat (10) @(posedge CORE_CLK);
    wr(`ICA_OFF_FLAGS_TWO, 32'hFFFFFFFB);
    rd(`ICA_OFF_FLAGS_TWO, 32'h0);
    wr(`ICA_OFF_EDGE_SEL, 32'h8);
    wr(`ICA_OFF_PIN_FUNC, 32'h7);
    repeat (8) @(posedge CORE_CLK);
    rd(`ICA_OFF_FLAGS_TWO, 32'h8);
    wr(`ICA_OFF_ENABLE_TWO, 32'hFF7);
    wr(`ICA_OFF_CCR, 32'h05);
    repeat (12) @(posedge CORE_CLK);
    chk(IMASK, 1'h0);
    rd(`ICA_OFF_STATUS, 32'h40);
    wr(`ICA_OFF_ENABLE_TWO, 32'hFFF);
    entry(5'h07, 16'h0505);
    close_out();
  end
endmodule : test_interrupt_accept_controller
